/* File: hbp_top.sv */
`timescale 1ns/100ps
`include "hbp_defines.svh"
module hbp_top
    import hbp_pkg::*;
(
    input  wire logic        I_CLOCK,        // 50 MHz system clock
    input  wire logic        I_RST_N,        // Synchronous reset, active low
    input  wire logic [3:0]  I_ADDRESS,      // Avalon word address
    input  wire logic        I_READ,         // Avalon read
    input  wire logic        I_WRITE,        // Avalon write
    input  wire logic [31:0] I_WRITEDATA,    // Avalon write data
    output logic      [31:0] O_READDATA,     // Avalon read data
    output logic             O_WAITREQUEST,  // Avalon wait request
    input  wire logic        I_SYNC_N,       // External sync, falling edge acts
    input  wire logic        I_TRIP_N,       // External trip, active low
    output logic      [5:0]  O_PWM,          // Modulator outputs
    output logic             O_TRIP_IRQ      // Pending trip interrupt
);
    hbp_req_type  req;
    hbp_pair_type pair_reg [3];
    hbp_pair_type work_reg [3];
    logic [15:0]  ctrl_reg;
    logic [15:0]  cnt_reg [3];
    logic [2:0]   hs_reg;
    logic [2:0]   ls_reg;
    logic [7:0]   pre_reg;
    logic         sync_reg;
    logic         irq_reg;
    logic         ack_reg;
    logic [31:0]  rdata_reg;

    assign req = '{address: I_ADDRESS, read: I_READ, write: I_WRITE,
                   writedata: I_WRITEDATA};

    // One word selects a pair and a field within it
    function automatic logic [15:0] pair_field(input hbp_pair_type p,
                                               input logic [1:0] f);
        unique case (f)
            2'h0: pair_field = p.rise;
            2'h1: pair_field = p.fall;
            2'h2: pair_field = p.low_fall;
            default: pair_field = p.period;
        endcase
    endfunction

    // Address decode
    wire       access   = req.read | req.write;
    wire       is_pair  = req.address >= `HBP_OFF_PAIR_BASE;
    wire [3:0] pair_off = req.address - `HBP_OFF_PAIR_BASE;
    wire [1:0] pair_sel = pair_off[3:2];
    wire [1:0] fld_sel  = pair_off[1:0];
    wire       pair_ok  = is_pair && (pair_sel != 2'h3);
    wire       wr_take  = req.write & ack_reg;
    wire       wr_ctrl  = wr_take && (req.address == `HBP_OFF_CTRL);
    wire       wr_clr   = wr_take && (req.address == `HBP_OFF_IRQ_CLR);

    // One wait state per access keeps read data registered
    assign O_WAITREQUEST = access & ~ack_reg;
    assign O_READDATA    = rdata_reg;

    // Prescaler tick: divide by 2 << code
    wire [2:0] pre_code = ctrl_reg[`HBP_B_PRE_LO +: 3];
    wire [7:0] pre_max  = 8'((9'h002 << pre_code) - 9'h001);
    wire       tick     = (pre_reg >= pre_max);
    wire       sync_hit = ctrl_reg[`HBP_B_SYNC] & sync_reg & ~I_SYNC_N;
    wire       trip_hit = ctrl_reg[`HBP_B_TRIP] & ~I_TRIP_N;

    // Bus access and control register
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            ctrl_reg  <= `HBP_CTRL_RESET;
            irq_reg   <= 1'b0;
        end else begin
            ack_reg <= access & ~ack_reg;
            if (access & ~ack_reg) begin
                if (req.address == `HBP_OFF_CTRL)
                    rdata_reg <= {16'h0000, ctrl_reg};
                else if (req.address == `HBP_OFF_STATUS)
                    rdata_reg <= {29'h0, I_TRIP_N, irq_reg, ctrl_reg[`HBP_B_GEN]};
                else if (pair_ok)
                    rdata_reg <= {16'h0000, pair_field(pair_reg[pair_sel], fld_sel)};
                else
                    rdata_reg <= 32'h0000_0000;
            end
            if (wr_ctrl)
                ctrl_reg <= I_WRITEDATA[15:0];
            if (trip_hit)
                ctrl_reg[`HBP_B_GEN] <= 1'b0;
            // Trip wins over the clear so no event is lost
            if (trip_hit)
                irq_reg <= 1'b1;
            else if (wr_clr)
                irq_reg <= 1'b0;
        end
    end
    assign O_TRIP_IRQ = irq_reg;

    // Pair register writes
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            for (int i = 0; i < 3; i++)
                pair_reg[i] <= '0;
        end else if (wr_take && pair_ok) begin
            unique case (fld_sel)
                2'h0: pair_reg[pair_sel].rise     <= I_WRITEDATA[15:0];
                2'h1: pair_reg[pair_sel].fall     <= I_WRITEDATA[15:0];
                2'h2: pair_reg[pair_sel].low_fall <= I_WRITEDATA[15:0];
                2'h3: pair_reg[pair_sel].period   <= I_WRITEDATA[15:0];
            endcase
        end
    end

    // Prescaler and sync edge memory
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            pre_reg  <= 8'h00;
            sync_reg <= 1'b1;
        end else begin
            sync_reg <= I_SYNC_N;
            pre_reg  <= tick ? 8'h00 : pre_reg + 8'h01;
        end
    end

    // Counters, working compares and raw waveforms per pair
    for (genvar p = 0; p < 3; p++) begin : g_pair
        wire [15:0] cnt     = cnt_reg[p];
        wire        at_rise = tick && (cnt == work_reg[p].rise);
        wire        at_fall = tick && (cnt == work_reg[p].fall);
        wire        at_lowf = tick && (cnt == work_reg[p].low_fall);
        wire        at_per  = tick && (cnt == pair_reg[p].period);
        always_ff @(posedge I_CLOCK) begin
            if (!I_RST_N) begin
                cnt_reg[p]  <= 16'h0000;
                work_reg[p] <= '0;
                hs_reg[p]   <= 1'b0;
                ls_reg[p]   <= 1'b0;
            end else begin
                if (sync_hit)
                    cnt_reg[p] <= 16'h0000;
                else if (tick)
                    cnt_reg[p] <= at_per ? 16'h0000 : cnt + 16'h0001;
                // Working copies refresh only at the 0 to 1 step
                if (tick && !at_per && cnt == 16'h0000 && ctrl_reg[`HBP_B_LOAD])
                    work_reg[p] <= pair_reg[p];
                if (at_fall)
                    hs_reg[p] <= 1'b0;
                else if (at_rise)
                    hs_reg[p] <= 1'b1;
                // Low side drops with high-side fall, whichever first
                if (at_lowf || (at_fall && hs_reg[p]))
                    ls_reg[p] <= 1'b0;
                else if (at_per)
                    ls_reg[p] <= 1'b1;
            end
        end
    end

    // Output selection; registered so pins never glitch
    wire       gen    = ctrl_reg[`HBP_B_GEN];
    wire       bridge = ctrl_reg[`HBP_B_BRIDGE];
    wire       high_side_off   = ctrl_reg[`HBP_B_HIGH_SIDE_OFF];
    wire [5:0] std_w  = {ls_reg[2], hs_reg[2], ls_reg[1], hs_reg[1],
                         ls_reg[0], hs_reg[0]};
    wire [5:0] inv_w  = {ctrl_reg[`HBP_B_INV5], 1'b0, ctrl_reg[`HBP_B_INV3], 1'b0,
                         ctrl_reg[`HBP_B_INV1], 1'b0};
    wire [3:0] dir_w  = ctrl_reg[`HBP_B_DIR] ? {2'b00, ls_reg[0], hs_reg[0]}
                                             : {ls_reg[0], hs_reg[0], 2'b00};
    wire [3:0] hb_w   = high_side_off ? 4'h5
                      : !ctrl_reg[`HBP_B_ENA] ? 4'hF
                      : ctrl_reg[`HBP_B_INVALL] ? ~dir_w : dir_w;
    wire [5:0] std_o  = (ctrl_reg[`HBP_B_INVALL] & bridge) ? ~(std_w ^ inv_w)
                                                          : (std_w ^ inv_w);
    wire [5:0] next_o = !gen ? 6'h00
                      : bridge ? {std_o[5:4], hb_w} : std_o;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N)
            O_PWM <= 6'h00;
        else
            O_PWM <= next_o;
    end
endmodule // hbp_top

/* File: hbp_defines.svh */
`ifndef HBP_DEFINES_SVH
`define HBP_DEFINES_SVH
`define HBP_OFF_CTRL      4'h0
`define HBP_OFF_IRQ_CLR   4'h1
`define HBP_OFF_STATUS    4'h2
`define HBP_OFF_PAIR_BASE 4'h4
`define HBP_CTRL_RESET    16'h0012
`define HBP_B_GEN         0
`define HBP_B_BRIDGE      1
`define HBP_B_DIR         2
`define HBP_B_LOAD        3
`define HBP_B_HIGH_SIDE_OFF        4
`define HBP_B_INVALL      5
`define HBP_B_PRE_LO      6
`define HBP_B_ENA         9
`define HBP_B_TRIP        10
`define HBP_B_INV1        11
`define HBP_B_INV3        12
`define HBP_B_INV5        13
`define HBP_B_SYNC        14
`endif

/* File: hbp_pkg.sv */
package hbp_pkg;
    typedef struct packed {
        logic [15:0] rise;
        logic [15:0] fall;
        logic [15:0] low_fall;
        logic [15:0] period;
    } hbp_pair_type;
    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } hbp_req_type;
endpackage

/* File: hbp_chk_asserts.sv */
`timescale 1ns/100ps
module hbp_chk (
    input wire logic        I_CLOCK,       // Clock
    input wire logic        I_RST_N,       // Reset
    input wire logic [3:0]  I_ADDRESS,     // Word address
    input wire logic        I_WRITE,       // Write
    input wire logic [31:0] I_WRITEDATA,   // Write data
    input wire logic        O_WAITREQUEST, // Wait
    input wire logic        I_TRIP_N,      // Trip line
    input wire logic [5:0]  O_PWM,         // Outputs
    input wire logic        O_TRIP_IRQ     // Trip irq
);
    logic [15:0] ctrl_reg;
    wire         wr_ok = I_WRITE && !O_WAITREQUEST;
    wire         clr   = wr_ok && I_ADDRESS == 4'h1;
    // Mirror of control writes; a trip clearing bit 0 is not mirrored
    always_ff @(posedge I_CLOCK)
        if (!I_RST_N) ctrl_reg <= 16'h0012;
        else if (wr_ok && I_ADDRESS == 4'h0) ctrl_reg <= I_WRITEDATA[15:0];
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    rst_quiet_a: assert property (disable iff (1'b0) !I_RST_N |=> O_PWM == 6'h00)
        else $error("outputs active after reset");
    wait_one_a: assert property (I_WRITE && O_WAITREQUEST |=> !O_WAITREQUEST)
        else $error("wait state too long");
    first_wait_a: assert property ($rose(I_WRITE) |-> O_WAITREQUEST)
        else $error("no wait state");
    trip_set_a: assert property (ctrl_reg[10] && !I_TRIP_N |-> ##[1:3] O_TRIP_IRQ)
        else $error("trip not raised");
    no_trip_a: assert property (!ctrl_reg[10] && !$past(ctrl_reg[10]) && !O_TRIP_IRQ
        |=> !O_TRIP_IRQ) else $error("trip while disabled");
    // A clear only wins while no enabled trip is pending in the same cycle
    irq_clear_a: assert property (clr && !(ctrl_reg[10] && !I_TRIP_N) |=> !O_TRIP_IRQ)
        else $error("irq not cleared");
    irq_hold_a: assert property (O_TRIP_IRQ && !clr |=> O_TRIP_IRQ)
        else $error("irq dropped");
    gen_off_a: assert property (!ctrl_reg[0] && !$past(ctrl_reg[0]) |-> O_PWM == 6'h00)
        else $error("outputs while disabled");
    high_side_off_a: assert property (ctrl_reg == $past(ctrl_reg) && ctrl_reg[5:0] == 6'h13
        && ctrl_reg[12:10] == 3'h0 |-> O_PWM[3:0] == 4'h5) else $error("high side off");
endmodule // hbp_chk
bind hbp_top hbp_chk u_chk (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_ADDRESS(I_ADDRESS),
    .I_WRITE(I_WRITE), .I_WRITEDATA(I_WRITEDATA), .O_WAITREQUEST(O_WAITREQUEST),
    .I_TRIP_N(I_TRIP_N), .O_PWM(O_PWM), .O_TRIP_IRQ(O_TRIP_IRQ));

/* File: hbp_stage.sv */
`timescale 1ns/100ps
module hbp_stage (
    input  wire logic i_clock,         // System clock
    input  wire logic i_fault,         // Bench orders an overcurrent
    input  wire logic i_sync_run,      // Bench orders sync pulses
    output logic      o_trip_n = 1'b1, // Fault line, idles high
    output logic      o_sync_n = 1'b1  // Sync line, idles high
);
    // Stage reports faults a clock late, as a real comparator would
    always_ff @(posedge i_clock) begin
        o_trip_n <= !i_fault;
        o_sync_n <= i_sync_run ? !o_sync_n : 1'b1;
    end
endmodule // hbp_stage

/* File: hbp_tb.sv */
`timescale 1ns/100ps
module tb
    import hbp_pkg::*;
();
    logic        clock = 1'b0, rst_n = 1'b0, sync_run = 1'b0, fault = 1'b0;
    hbp_req_type req = '0;
    logic [31:0] rdata;
    logic [5:0]  pwm;
    logic        wait_req, irq, trip_n, sync_n;
    logic [31:0] cfg [4] = '{32'h2, 32'h6, 32'h9, 32'hC};
    int          error_cnt = 0, cmp_count = 0, cyc = 0, d;
    logic [31:0] cnt [6];
    always #10 clock = ~clock;
    hbp_top dut (.I_CLOCK(clock), .I_RST_N(rst_n), .I_ADDRESS(req.address),
        .I_READ(req.read), .I_WRITE(req.write), .I_WRITEDATA(req.writedata),
        .O_READDATA(rdata), .O_WAITREQUEST(wait_req), .I_SYNC_N(sync_n),
        .I_TRIP_N(trip_n), .O_PWM(pwm), .O_TRIP_IRQ(irq));
    hbp_stage stage (.i_clock(clock), .i_fault(fault), .i_sync_run(sync_run),
        .o_trip_n(trip_n), .o_sync_n(sync_n));
    task automatic finish_test;
        if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    // Request held until waitrequest is sampled low at an edge
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] wd);
        @(posedge clock);
        req <= '{a, !w, w, wd};
        do @(posedge clock); while (wait_req !== 1'b0);
        req <= '0;
    endtask
    // Settle two windows so new compares load, then count high clocks
    task automatic run(input logic [15:0] c);
        bus(4'h0, 1'b1, {16'h0000, c});
        d = 2 << c[8:6];
        repeat (26 * d) @(posedge clock);
        cnt = '{default: 0};
        repeat (26 * d) begin
            @(posedge clock);
            for (int b = 0; b < 6; b++) cnt[b] += pwm[b];
        end
    endtask
    // Hang guard, well above the run's length
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test;
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        chk("reset outputs", pwm, 0);
        bus(4'h0, 1'b0, 0);
        chk("ctrl reset", rdata, 32'h12);
        bus(4'h3, 1'b1, 32'hFFFF);
        bus(4'h3, 1'b0, 0);
        chk("unmapped", rdata, 0);
        for (int p = 0; p < 3; p++)
            for (int r = 0; r < 4; r++) bus(4'(4 + 4 * p + r), 1'b1, cfg[r]);
        bus(4'hB, 1'b0, 0);
        chk("pair1 period", rdata, 32'hC);
        sync_run <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            run(k ? 16'h3849 : 16'h0009);
            for (int b = 0; b < 6; b++)
                chk("pair count", cnt[b], b % 2 ? (k ? 12 * d : 14 * d) : 8 * d);
        end
        // Arm sync just after the high side falls, so frozen counters leave both sides low
        while (pwm[0] !== 1'b1) @(posedge clock);
        while (pwm[0] !== 1'b0) @(posedge clock);
        run(16'h4009);
        chk("sync hold", cnt[0], 0);
        chk("sync hold low", cnt[1], 0);
        sync_run <= 1'b0;
        // Direction low, direction high, then invert-all with direction low
        for (int k = 0; k < 3; k++) begin
            run(k == 2 ? 16'h022B : (k ? 16'h020F : 16'h020B));
            chk("bridge out0", cnt[0], k == 2 ? 26 * d : (k ? 8 * d : 0));
            chk("bridge out2", cnt[2], k == 2 ? 18 * d : (k ? 0 : 8 * d));
        end
        chk("invert out4", cnt[4], 18 * d);
        bus(4'h0, 1'b1, 32'h13);
        repeat (3) @(posedge clock);
        chk("high off", pwm[3:0], 4'h5);
        bus(4'h0, 1'b1, 32'h3);
        repeat (3) @(posedge clock);
        chk("bridge off", pwm[3:0], 4'hF);
        bus(4'h0, 1'b1, 32'h409);
        fault <= 1'b1;
        repeat (4) @(posedge clock);
        chk("trip irq", irq, 1);
        bus(4'h2, 1'b0, 0);
        chk("status", rdata, 32'h2);
        fault <= 1'b0;
        repeat (4) @(posedge clock);
        bus(4'h1, 1'b1, 0);
        repeat (2) @(posedge clock);
        chk("irq clear", irq, 0);
        bus(4'h0, 1'b1, 32'h9);
        fault <= 1'b1;
        repeat (4) @(posedge clock);
        chk("trip masked", irq, 0);
        finish_test;
    end
endmodule // tb
